// File: hdl/rxfp_map.vh
// Register offsets, field positions, reset values and sizes of the receive queue path
`ifndef RXFP_MAP_VH
`define RXFP_MAP_VH

// APB byte addresses
`define RXFP_ADDR_DATA    8'h00
`define RXFP_ADDR_STAT    8'h04
`define RXFP_ADDR_INFO    8'h08
`define RXFP_ADDR_CFG     8'h0c
`define RXFP_ADDR_PATH    8'h10
`define RXFP_ADDR_MAC     8'h14
`define RXFP_ADDR_RST     8'h18

// rx_config fields
`define RXFP_CFG_OFF_HI   4
`define RXFP_CFG_PAD      8
`define RXFP_CFG_BURST_LO 9
`define RXFP_CFG_BURST_HI 10
`define RXFP_CFG_DUMP     15

// rx_path_control, mac_control and soft reset fields
`define RXFP_PATH_SKIP    31
`define RXFP_MAC_RECEIVER_ENABLE     2
`define RXFP_MAC_PASSBAD  16
`define RXFP_RST_SOFT     0
`define RXFP_RST_ERR      1
`define RXFP_RST_HALT     2

// Status word layout
`define RXFP_ST_FAIL      30
`define RXFP_ST_LEN_HI    29
`define RXFP_ST_LEN_LO    16
`define RXFP_ST_ES        15
`define RXFP_ST_BCAST     13
`define RXFP_ST_LENERR    12
`define RXFP_ST_RUNT      11
`define RXFP_ST_MCAST     10
`define RXFP_ST_LONG      7
`define RXFP_ST_LATE      6
`define RXFP_ST_CRC       1

// Queue address widths and data queue room limit
`define RXFP_D_AW         9
`define RXFP_S_AW         4
`define RXFP_B_AW         5
`define RXFP_D_SAFE       10'h1fd

// Reset values
`define RXFP_CFG_RESET    5'h00
`define RXFP_BURST_RESET  2'h0

`endif

// File: hdl/rxfp_queue.v
// Pointer-based word queue used for data, status and packet boundaries
`timescale 1ns/1ns
`default_nettype none
module rxfp_queue #(
   parameter W = 32,
   parameter A = 4
) (
   input  wire         i_clock,  // System clock
   input  wire         i_clear,  // Return both pointers to zero
   input  wire         i_push,   // Store i_wdata
   input  wire [W-1:0] i_wdata,  // Word to store
   input  wire         i_pop,    // Drop head word
   input  wire         i_jump,   // Load read pointer
   input  wire [A:0]   i_jptr,   // New read pointer
   input  wire         i_rewind, // Load write pointer
   input  wire [A:0]   i_wptr,   // New write pointer
   output wire [W-1:0] o_rdata,  // Head word
   output wire [A:0]   o_count,  // Words held
   output wire [A:0]   o_rptr,   // Read pointer
   output wire [A:0]   o_wp      // Write pointer
);
   reg [W-1:0] mem [0:(1<<A)-1];
   reg [A:0]   wp;
   reg [A:0]   rp;

   always @(posedge i_clock) begin
      if (i_push)
         mem[wp[A-1:0]] <= i_wdata;
      if (i_clear)
         wp <= {(A+1){1'b0}};
      else if (i_rewind)
         wp <= i_wptr;
      else if (i_push)
         wp <= wp + 1'b1;
      // A jump wins over a pop: it already moves past the head word
      if (i_clear)
         rp <= {(A+1){1'b0}};
      else if (i_jump)
         rp <= i_jptr;
      else if (i_pop)
         rp <= rp + 1'b1;
   end

   assign o_rdata = mem[rp[A-1:0]];
   assign o_count = wp - rp;
   assign o_rptr  = rp;
   assign o_wp    = wp;
endmodule // rxfp_queue
`default_nettype wire

// File: hdl/rxfp_top.v
// Receive queue path: frame data and status queues drained by the host over APB
`include "rxfp_map.vh"
`timescale 1ns/1ns
`default_nettype none
module rxfp_top (
   input  wire        i_clock,                // 100 MHz system clock
   input  wire        i_resetn,               // Synchronous reset, active low
   input  wire        i_psel,                 // APB select
   input  wire        i_penable,              // APB access phase
   input  wire        i_pwrite,               // APB write
   input  wire [7:0]  i_paddr,                // APB byte address
   input  wire [31:0] i_pwdata,               // APB write data
   output reg  [31:0] o_prdata,               // APB read data
   output reg         o_pready,               // APB ready
   output reg         o_pslverr,              // APB error, unmapped address
   input  wire        i_mil_valid,            // Frame word offered
   input  wire [31:0] i_mil_data,             // Frame word, first byte low
   input  wire        i_mil_last,             // Last word of the frame
   input  wire [13:0] i_mil_len,              // Frame length in bytes, with last
   input  wire        i_mil_filter_fail,      // Address filter failed
   input  wire        i_mil_broadcast,        // Broadcast destination
   input  wire        i_mil_multicast,        // Multicast destination
   input  wire        i_mil_length_mismatch,  // Length/type field mismatch
   input  wire        i_mil_runt,             // Frame shorter than 64 bytes
   input  wire        i_mil_too_long,         // Frame longer than 1518 bytes
   input  wire        i_mil_late_collision,   // Late collision seen
   input  wire        i_mil_crc_error,        // Checksum error
   input  wire        i_mil_rx_error,         // Receive error during frame
   output reg         o_mil_ready,            // Frame word taken when valid
   output reg         o_receiver_enable,      // Reception enabled
   output reg         o_rx_error_flag,        // Sticky receive error
   output reg         o_receiver_halted_event // One-cycle halt pulse
);
   localparam S_IDLE  = 6'h01;
   localparam S_LEAD  = 6'h02;
   localparam S_DATA  = 6'h04;
   localparam S_FLUSH = 6'h08;
   localparam S_PAD   = 6'h10;
   localparam S_STAT  = 6'h20;

   reg  [5:0]  state;
   reg  [5:0]  next_state;
   reg         soft_rst;
   reg  [4:0]  cfg_off;
   reg         cfg_pad;
   reg  [1:0]  cfg_burst;
   reg         dump;
   reg         skip;
   reg         pass_bad;
   reg         halted_q;
   reg  [4:0]  off_q;
   reg  [2:0]  lead;
   reg  [31:0] carry;
   reg  [12:0] wcnt;
   reg  [13:0] len_q;
   reg  [31:0] st_q;
   reg  [10:0] pkt_start;
   reg         d_push;
   reg  [31:0] d_wdata;
   reg         s_push;
   reg         b_push;
   reg         rewind;
   reg         s_over;
   reg  [31:0] rd_mux;
   reg         hit;

   wire        rst_all = ~i_resetn | soft_rst;
   wire        clr = rst_all | dump;
   wire        done = i_psel & i_penable & o_pready;
   wire        wr = done & i_pwrite;
   wire        rd = done & ~i_pwrite;
   wire        wr_cfg = wr & (i_paddr == `RXFP_ADDR_CFG);
   wire        wr_path = wr & (i_paddr == `RXFP_ADDR_PATH);
   wire        wr_mac = wr & (i_paddr == `RXFP_ADDR_MAC);
   wire        wr_rst = wr & (i_paddr == `RXFP_ADDR_RST);
   wire        rd_data = rd & (i_paddr == `RXFP_ADDR_DATA);
   wire        rd_stat = rd & (i_paddr == `RXFP_ADDR_STAT);

   wire [31:0] d_rdata;
   wire [9:0]  d_cnt;
   wire [9:0]  d_rptr;
   wire [9:0]  d_wptr;
   wire [31:0] s_rdata;
   wire [4:0]  s_cnt;
   wire [9:0]  b_head;
   wire [5:0]  b_cnt;

   wire        d_full = d_cnt[`RXFP_D_AW];
   wire        s_full = s_cnt[`RXFP_S_AW];
   wire        b_full = b_cnt[`RXFP_B_AW];
   wire        accept = i_mil_valid & o_mil_ready;
   wire        d_pop = rd_data & (d_cnt != 10'h000);
   wire        s_pop = rd_stat & (s_cnt != 5'h00);
   wire        underrun = (rd_data & (d_cnt == 10'h000)) |
                          (rd_stat & (s_cnt == 5'h00));
   // Skip waits for the head packet's end mark, so it never cuts a frame in flight
   wire        skip_go = skip & (b_cnt != 6'h00);
   wire        b_pop = skip_go |
                       (d_pop & ((d_rptr + 10'h001) == b_head) & (b_cnt != 6'h00));
   wire [63:0] shifted = rxfp_shift(i_mil_data, off_q[1:0]);
   wire [14:0] total = {10'h000, off_q} + {1'b0, len_q} + 15'h0003;
   wire [12:0] need_words = total[14:2];
   wire [3:0]  bmask = (4'h1 << cfg_burst) - 4'h1;
   wire        pad_need = cfg_pad & ((wcnt[3:0] & bmask) != 4'h0);
   wire        drop_runt = i_mil_runt & ~pass_bad;
   wire        halted_now = ~o_receiver_enable & state[0];

   function [63:0] rxfp_shift;
      input [31:0] d;
      input [1:0]  sh;
      begin
         rxfp_shift = {32'h0, d} << {sh, 3'b000};
      end
   endfunction

   function [31:0] rxfp_status;
      input [13:0] len;
      input        fail;
      input        bc;
      input        le;
      input        runt;
      input        mc;
      input        lng;
      input        late;
      input        crc;
      begin
         rxfp_status = 32'h0;
         rxfp_status[`RXFP_ST_FAIL] = fail;
         rxfp_status[`RXFP_ST_LEN_HI:`RXFP_ST_LEN_LO] = len;
         rxfp_status[`RXFP_ST_ES] = runt | lng | late | crc;
         rxfp_status[`RXFP_ST_BCAST] = bc;
         rxfp_status[`RXFP_ST_LENERR] = le;
         rxfp_status[`RXFP_ST_RUNT] = runt;
         rxfp_status[`RXFP_ST_MCAST] = mc;
         rxfp_status[`RXFP_ST_LONG] = lng;
         rxfp_status[`RXFP_ST_LATE] = late;
         rxfp_status[`RXFP_ST_CRC] = crc;
      end
   endfunction

   // Write side sequencing: lead words, shifted data, spill, padding, status
   always @* begin
      next_state = state;
      d_push = 1'b0;
      d_wdata = 32'h0;
      s_push = 1'b0;
      b_push = 1'b0;
      rewind = 1'b0;
      s_over = 1'b0;
      case (state)
         S_IDLE: begin
            if (i_mil_valid & o_receiver_enable & ~dump) begin
               if (cfg_off[`RXFP_CFG_OFF_HI:2] != 3'h0)
                  next_state = S_LEAD;
               else
                  next_state = S_DATA;
            end
         end
         S_LEAD: begin
            if (~d_full) begin
               d_push = 1'b1;
               if (lead == 3'h1)
                  next_state = S_DATA;
            end
         end
         S_DATA: begin
            if (accept) begin
               d_push = 1'b1;
               d_wdata = shifted[31:0] | carry;
               if (i_mil_last) begin
                  if (drop_runt) begin
                     rewind = 1'b1;
                     next_state = S_IDLE;
                  end else begin
                     next_state = S_FLUSH;
                  end
               end
            end
         end
         S_FLUSH: begin
            if (wcnt < need_words) begin
               if (~d_full) begin
                  d_push = 1'b1;
                  d_wdata = carry;
                  next_state = S_PAD;
               end
            end else begin
               next_state = S_PAD;
            end
         end
         S_PAD: begin
            if (pad_need) begin
               d_push = ~d_full;
            end else begin
               next_state = S_STAT;
            end
         end
         S_STAT: begin
            if (~b_full) begin
               b_push = 1'b1;
               s_push = ~s_full;
               s_over = s_full;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always @(posedge i_clock) begin
      if (rst_all) begin
         state <= S_IDLE;
         off_q <= 5'h00;
         lead <= 3'h0;
         carry <= 32'h0;
         wcnt <= 13'h0000;
         len_q <= 14'h0000;
         st_q <= 32'h0;
         pkt_start <= 11'h000;
         o_mil_ready <= 1'b0;
      end else begin
         state <= next_state;
         o_mil_ready <= (next_state == S_DATA) & (d_cnt < `RXFP_D_SAFE);
         if (d_push)
            wcnt <= wcnt + 13'h0001;
         case (state)
            S_IDLE: begin
               // Offset is latched per packet so a late change cannot tear one
               off_q <= cfg_off;
               lead <= cfg_off[`RXFP_CFG_OFF_HI:2];
               carry <= 32'h0;
               wcnt <= 13'h0000;
               pkt_start <= {1'b0, d_wptr};
            end
            S_LEAD: begin
               if (~d_full)
                  lead <= lead - 3'h1;
            end
            S_DATA: begin
               if (accept) begin
                  carry <= shifted[63:32];
                  if (i_mil_last) begin
                     len_q <= i_mil_len;
                     st_q <= rxfp_status(i_mil_len, i_mil_filter_fail,
                                         i_mil_broadcast, i_mil_length_mismatch,
                                         i_mil_runt, i_mil_multicast, i_mil_too_long,
                                         i_mil_late_collision,
                                         i_mil_crc_error | i_mil_rx_error);
                  end
               end
            end
            default: begin
               carry <= carry;
            end
         endcase
      end
   end

   // Control registers; a hardware clear never wipes a same-cycle write
   always @(posedge i_clock) begin
      if (rst_all) begin
         cfg_off <= `RXFP_CFG_RESET;
         cfg_pad <= 1'b0;
         cfg_burst <= `RXFP_BURST_RESET;
         dump <= 1'b0;
         skip <= 1'b0;
         pass_bad <= 1'b0;
         o_receiver_enable <= 1'b0;
         o_rx_error_flag <= 1'b0;
         halted_q <= 1'b1;
         o_receiver_halted_event <= 1'b0;
      end else begin
         if (wr_cfg) begin
            cfg_off <= i_pwdata[`RXFP_CFG_OFF_HI:0];
            cfg_pad <= i_pwdata[`RXFP_CFG_PAD];
            cfg_burst <= i_pwdata[`RXFP_CFG_BURST_HI:`RXFP_CFG_BURST_LO];
         end
         // Queues clear at the edge that ends the cycle dump is high, so it drops after one cycle
         dump <= wr_cfg & i_pwdata[`RXFP_CFG_DUMP];
         if (wr_path)
            skip <= i_pwdata[`RXFP_PATH_SKIP];
         else if (skip_go)
            skip <= 1'b0;
         if (wr_mac) begin
            o_receiver_enable <= i_pwdata[`RXFP_MAC_RECEIVER_ENABLE];
            pass_bad <= i_pwdata[`RXFP_MAC_PASSBAD];
         end
         if (underrun | s_over)
            o_rx_error_flag <= 1'b1;
         halted_q <= halted_now;
         o_receiver_halted_event <= halted_now & ~halted_q;
      end
   end

   // Soft reset lives outside rst_all so that it can end itself
   always @(posedge i_clock) begin
      if (~i_resetn)
         soft_rst <= 1'b0;
      else
         soft_rst <= wr_rst & i_pwdata[`RXFP_RST_SOFT];
   end

   always @* begin
      rd_mux = 32'h0;
      hit = 1'b1;
      case (i_paddr)
         `RXFP_ADDR_DATA: rd_mux = d_rdata;
         `RXFP_ADDR_STAT: rd_mux = s_rdata;
         `RXFP_ADDR_INFO: rd_mux = {8'h00, 3'h0, s_cnt, 6'h00, d_cnt};
         `RXFP_ADDR_CFG: begin
            rd_mux[`RXFP_CFG_OFF_HI:0] = cfg_off;
            rd_mux[`RXFP_CFG_PAD] = cfg_pad;
            rd_mux[`RXFP_CFG_BURST_HI:`RXFP_CFG_BURST_LO] = cfg_burst;
            rd_mux[`RXFP_CFG_DUMP] = dump;
         end
         `RXFP_ADDR_PATH: rd_mux[`RXFP_PATH_SKIP] = skip;
         `RXFP_ADDR_MAC: begin
            rd_mux[`RXFP_MAC_RECEIVER_ENABLE] = o_receiver_enable;
            rd_mux[`RXFP_MAC_PASSBAD] = pass_bad;
         end
         `RXFP_ADDR_RST: begin
            rd_mux[`RXFP_RST_ERR] = o_rx_error_flag;
            rd_mux[`RXFP_RST_HALT] = halted_now;
         end
         default: hit = 1'b0;
      endcase
      // An empty queue reads as zero rather than stale storage
      if ((i_paddr == `RXFP_ADDR_DATA) & (d_cnt == 10'h000))
         rd_mux = 32'h0;
      if ((i_paddr == `RXFP_ADDR_STAT) & (s_cnt == 5'h00))
         rd_mux = 32'h0;
   end

   // One wait state per transfer keeps every APB output on a flop
   always @(posedge i_clock) begin
      if (rst_all) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0;
         o_pslverr <= 1'b0;
      end else if (i_psel & i_penable & ~o_pready) begin
         o_pready <= 1'b1;
         o_prdata <= i_pwrite ? 32'h0 : rd_mux;
         o_pslverr <= ~hit;
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   rxfp_queue #(.W(32), .A(`RXFP_D_AW)) u_data (
      .i_clock  (i_clock),
      .i_clear  (clr),
      .i_push   (d_push),
      .i_wdata  (d_wdata),
      .i_pop    (d_pop),
      .i_jump   (skip_go),
      .i_jptr   (b_head),
      .i_rewind (rewind),
      .i_wptr   (pkt_start[9:0]),
      .o_rdata  (d_rdata),
      .o_count  (d_cnt),
      .o_rptr   (d_rptr),
      .o_wp     (d_wptr)
   );

   // Status pointers ignore skip entirely
   rxfp_queue #(.W(32), .A(`RXFP_S_AW)) u_stat (
      .i_clock  (i_clock),
      .i_clear  (clr),
      .i_push   (s_push),
      .i_wdata  (st_q),
      .i_pop    (s_pop),
      .i_jump   (1'b0),
      .i_jptr   (5'h00),
      .i_rewind (1'b0),
      .i_wptr   (5'h00),
      .o_rdata  (s_rdata),
      .o_count  (s_cnt),
      .o_rptr   (),
      .o_wp     ()
   );

   // End mark of each packet in the data queue, used by skip
   rxfp_queue #(.W(10), .A(`RXFP_B_AW)) u_bound (
      .i_clock  (i_clock),
      .i_clear  (clr),
      .i_push   (b_push),
      .i_wdata  (d_wptr),
      .i_pop    (b_pop),
      .i_jump   (1'b0),
      .i_jptr   (6'h00),
      .i_rewind (1'b0),
      .i_wptr   (6'h00),
      .o_rdata  (b_head),
      .o_count  (b_cnt),
      .o_rptr   (),
      .o_wp     ()
   );
endmodule // rxfp_top
`default_nettype wire

// File: tb/rxfp_props.sv
// Port-level checks of the receive queue path
`timescale 1ns/1ns
`default_nettype none
module rxfp_props (
   input wire logic        i_clock,                // Clock
   input wire logic        i_resetn,               // Reset, active low
   input wire logic        i_psel,                 // APB select
   input wire logic        i_penable,              // APB access
   input wire logic        i_pwrite,               // APB write
   input wire logic [7:0]  i_paddr,                // APB address
   input wire logic [31:0] i_pwdata,               // APB write data
   input wire logic [31:0] o_prdata,               // APB read data
   input wire logic        o_pready,               // APB ready
   input wire logic        o_pslverr,              // APB error
   input wire logic        i_mil_valid,            // Word offered
   input wire logic        i_mil_last,             // Last word
   input wire logic        o_mil_ready,            // Word taken
   input wire logic        o_receiver_enable,      // Reception on
   input wire logic        o_rx_error_flag,        // Sticky error
   input wire logic        o_receiver_halted_event // Halt pulse
);
   logic soft_hit;
   assign soft_hit = o_pready && i_pwrite && i_paddr == 8'h18 && i_pwdata[0];
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   sequence apb_first; i_psel && i_penable && !$past(i_penable); endsequence
   sequence stat_rd; o_pready && !i_pwrite && i_paddr == 8'h04; endsequence
   sequence word_last; i_mil_valid && o_mil_ready && i_mil_last; endsequence
   one_wait_a: assert property (apb_first |=> o_pready) else $error("ready not after one wait");
   ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
   err_decode_a: assert property (o_pready && i_paddr[1:0] == 2'h0
      |-> o_pslverr == (i_paddr > 8'h18) && (!o_pslverr || o_prdata == 32'h0))
      else $error("bad error response");
   stat_reserved_a: assert property (stat_rd |-> !o_prdata[31] && !o_prdata[14])
      else $error("reserved status bit set");
   stat_summary_a: assert property (stat_rd
      |-> o_prdata[15] == (o_prdata[11] | o_prdata[7] | o_prdata[6] | o_prdata[1]))
      else $error("summary error bit wrong");
   err_sticky_a: assert property ($fell(o_rx_error_flag) |-> $past(soft_hit, 2))
      else $error("error flag cleared without soft reset");
   err_clear_a: assert property (soft_hit |-> ##2 !o_rx_error_flag)
      else $error("soft reset kept error flag");
   halt_pulse_a: assert property (o_receiver_halted_event |=> !o_receiver_halted_event)
      else $error("halt event longer than one cycle");
   halt_off_a: assert property (o_receiver_halted_event |-> !o_receiver_enable)
      else $error("halt event while enabled");
   last_drop_a: assert property (word_last |=> !o_mil_ready)
      else $error("ready kept after last word");
   start_en_a: assert property ($rose(o_mil_ready) |-> $past(o_receiver_enable))
      else $error("frame accepted while disabled");
endmodule // rxfp_props
bind rxfp_top rxfp_props u_rxfp_props (.i_clock(i_clock), .i_resetn(i_resetn),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_mil_valid(i_mil_valid), .i_mil_last(i_mil_last), .o_mil_ready(o_mil_ready),
   .o_receiver_enable(o_receiver_enable), .o_rx_error_flag(o_rx_error_flag),
   .o_receiver_halted_event(o_receiver_halted_event));
`default_nettype wire

// File: tb/rxfp_mil_src.sv
// Frame source standing in for the MAC interface layer
`timescale 1ns/1ns
`default_nettype none
module rxfp_mil_src (
   input  wire logic        i_clock, // Clock
   input  wire logic        i_ready, // Word taken with valid
   output var  logic        o_valid, // Word offered
   output var  logic [31:0] o_data,  // Frame word, first byte low
   output var  logic        o_last,  // Last word
   output var  logic [13:0] o_len,   // Length, valid with last
   output var  logic [8:0]  o_flags  // Status inputs, valid with last
);
   initial begin
      o_valid = 1'h0;
      o_data = 32'h0;
      o_last = 1'h0;
      o_len = 14'h0;
      o_flags = 9'h0;
   end
   // Side inputs carry inverted values off the last word, so early sampling shows
   task automatic send(input int len, input logic [8:0] fl, input int base, input int gap);
      int i;
      int t;
      i = 0;
      t = 0;
      while (i < (len + 3) / 4 && t < 3000) begin
         o_valid <= 1'h1;
         o_data <= {8'(base + 4 * i + 3), 8'(base + 4 * i + 2), 8'(base + 4 * i + 1),
                    8'(base + 4 * i)};
         o_last <= (i == (len + 3) / 4 - 1);
         o_len <= (i == (len + 3) / 4 - 1) ? 14'(len) : ~14'(len);
         o_flags <= (i == (len + 3) / 4 - 1) ? fl : ~fl;
         @(posedge i_clock);
         t++;
         if (i_ready === 1'h1) begin
            i++;
            if (gap > 0) begin
               o_valid <= 1'h0;
               o_data <= ~o_data;
               repeat (gap) @(posedge i_clock);
            end
         end
      end
      o_valid <= 1'h0;
      o_last <= 1'h0;
      o_data <= ~o_data;
      o_flags <= ~fl;
      @(posedge i_clock);
   endtask
endmodule // rxfp_mil_src
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the receive queue path
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clock, resetn, psel, penable, pwrite, pready, pslverr, perr;
   logic        mv, ml, mr, ren, rxerr, halt, halt_seen;
   logic [7:0]  paddr;
   logic [8:0]  fl;
   logic [13:0] mlen;
   logic [31:0] pwdata, prdata, md, q;
   int          fails, num_checks, t;
   rxfp_top u_rxfp_top (.i_clock(clock), .i_resetn(resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mil_valid(mv),
      .i_mil_data(md), .i_mil_last(ml), .i_mil_len(mlen), .i_mil_filter_fail(fl[8]),
      .i_mil_broadcast(fl[7]), .i_mil_multicast(fl[6]), .i_mil_length_mismatch(fl[5]),
      .i_mil_runt(fl[4]), .i_mil_too_long(fl[3]), .i_mil_late_collision(fl[2]),
      .i_mil_crc_error(fl[1]), .i_mil_rx_error(fl[0]), .o_mil_ready(mr),
      .o_receiver_enable(ren), .o_rx_error_flag(rxerr), .o_receiver_halted_event(halt));
   rxfp_mil_src u_rxfp_mil_src (.i_clock(clock), .i_ready(mr), .o_valid(mv), .o_data(md),
      .o_last(ml), .o_len(mlen), .o_flags(fl));
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (halt === 1'h1) halt_seen <= 1'h1;
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic give_up;
      fails++;
      end_of_test();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      int n;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) give_up();
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic wait_stat(input int n);
      t = 0;
      do begin
         apb(1'h0, 8'h08, 32'h0, q);
         t++;
      end while (q[20:16] < n && t < 60);
      if (t >= 60) give_up();
   endtask
   function automatic logic [31:0] stat(input int len, input logic [8:0] f);
      stat = {1'h0, f[8], 14'(len), |f[4:0], 1'h0, f[7], f[5], f[4], f[6], 2'h0, f[3], f[2],
              4'h0, f[1] | f[0], 1'h0};
   endfunction
   // Host side reads status first, then offset, length and padding of data
   task automatic drain(input int len, input logic [8:0] f, input int base, input int off,
                        input int bw);
      logic [31:0] rd;
      int n;
      apb(1'h0, 8'h04, 32'h0, rd);
      check(rd, stat(len, f));
      n = ((off + len + 3) / 4 + bw - 1) / bw * bw;
      for (int w = 0; w < n; w++) begin
         apb(1'h0, 8'h00, 32'h0, rd);
         for (int k = 0; k < 4; k++)
            if (4 * w + k >= off && 4 * w + k < off + len)
               check({24'h0, rd[8 * k +: 8]}, {24'h0, 8'(base + 4 * w + k - off)});
      end
   endtask
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, halt_seen, fails, num_checks} = '0;
      repeat (10) @(posedge clock);
      resetn <= 1'h1;
      @(posedge clock);
      apb(1'h0, 8'h0c, 32'h0, q);
      check(q, 32'h0);
      apb(1'h0, 8'h40, 32'h0, q);
      check({q[31:1], perr}, 32'h1);
      apb(1'h1, 8'h14, 32'h00010004, q);
      for (int k = 0; k < 10; k++) begin
         u_rxfp_mil_src.send(64, (k == 9) ? 9'h1ff : 9'(1 << k), 16 * k, k % 2);
         wait_stat(1);
         drain(64, (k == 9) ? 9'h1ff : 9'(1 << k), 16 * k, 0, 1);
      end
      apb(1'h1, 8'h14, 32'h4, q);
      u_rxfp_mil_src.send(60, 9'h010, 0, 0);
      u_rxfp_mil_src.send(8, 9'h0, 32, 0);
      wait_stat(1);
      drain(8, 9'h0, 32, 0, 1);
      // Offset 31, padding on, burst of four words
      apb(1'h1, 8'h0c, 32'h0000051f, q);
      u_rxfp_mil_src.send(9, 9'h0, 64, 0);
      u_rxfp_mil_src.send(13, 9'h0, 128, 1);
      wait_stat(2);
      check(q, 32'h00020018);
      drain(9, 9'h0, 64, 31, 4);
      drain(13, 9'h0, 128, 31, 4);
      apb(1'h1, 8'h0c, 32'h3, q);
      u_rxfp_mil_src.send(6, 9'h0, 200, 0);
      wait_stat(1);
      drain(6, 9'h0, 200, 3, 1);
      u_rxfp_mil_src.send(32, 9'h0, 16, 0);
      u_rxfp_mil_src.send(12, 9'h0, 96, 0);
      wait_stat(2);
      apb(1'h1, 8'h10, 32'h80000000, q);
      t = 0;
      do begin
         apb(1'h0, 8'h10, 32'h0, q);
         t++;
      end while (q[31] !== 1'h0 && t < 40);
      check({31'h0, q[31]}, 32'h0);
      apb(1'h0, 8'h04, 32'h0, q);
      check(q, stat(32, 9'h0));
      drain(12, 9'h0, 96, 3, 1);
      for (int k = 0; k < 17; k++) u_rxfp_mil_src.send(4, 9'h0, k, 0);
      wait_stat(16);
      repeat (8) @(posedge clock);
      apb(1'h0, 8'h08, 32'h0, q);
      check({q[31:10], 10'h0}, 32'h00100000);
      check({31'h0, rxerr}, 32'h1);
      apb(1'h1, 8'h18, 32'h1, q);
      @(posedge clock);
      apb(1'h0, 8'h08, 32'h0, q);
      check(q, 32'h0);
      apb(1'h0, 8'h04, 32'h0, q);
      check(q, 32'h0);
      apb(1'h0, 8'h18, 32'h0, q);
      check({31'h0, q[1]}, 32'h1);
      apb(1'h1, 8'h18, 32'h1, q);
      @(posedge clock);
      apb(1'h1, 8'h14, 32'h4, q);
      u_rxfp_mil_src.send(8, 9'h0, 0, 0);
      wait_stat(1);
      check({31'h0, halt_seen}, 32'h0);
      apb(1'h1, 8'h14, 32'h0, q);
      t = 0;
      while (halt_seen !== 1'h1 && t < 100) begin
         @(posedge clock);
         t++;
      end
      check({31'h0, halt_seen}, 32'h1);
      apb(1'h1, 8'h0c, 32'h00008000, q);
      apb(1'h0, 8'h0c, 32'h0, q);
      check(q, 32'h0);
      apb(1'h0, 8'h08, 32'h0, q);
      check(q, 32'h0);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
